// >>> hdl/dcc_pkg.sv
package dcc_pkg;

    // ----------------------------------------------------------------
    // Bus geometry and answers
    // ----------------------------------------------------------------
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int NUM_CMP = 2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------------------------------
    // Register byte addresses, one aligned word each
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_INSEL0 = 8'h04;
    localparam logic [7:0] ADDR_MODE0 = 8'h08;
    localparam logic [7:0] ADDR_CTRL1 = 8'h0C;
    localparam logic [7:0] ADDR_INSEL1 = 8'h10;
    localparam logic [7:0] ADDR_MODE1 = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

    // ----------------------------------------------------------------
    // Reset values and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] INSEL_RESET = 8'hFF;
    localparam logic [7:0] MODE_RESET = 8'h02;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [7:0] CTRL_STORED = 8'h8F;
    localparam logic [7:0] INSEL_STORED = 8'h33;
    localparam logic [7:0] INSEL_FORCED_ONES = 8'hCC;
    localparam logic [7:0] MODE_STORED = 8'h33;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;
    localparam int INSEL_NEG_LSB = 4;
    localparam int INSEL_POS_LSB = 0;
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_RESP_LSB = 0;

    // ----------------------------------------------------------------
    // Input pin tables, element index = select code, value 8'hPB = Pp.b
    // ----------------------------------------------------------------
    localparam logic [3:0][7:0] C0N_PINS_32 = {8'h36, 8'h32, 8'h24, 8'h15};
    localparam logic [3:0][7:0] C0N_PINS = {8'h25, 8'h21, 8'h15, 8'h11};
    localparam logic [3:0][7:0] C0P_PINS_32 = {8'h35, 8'h31, 8'h23, 8'h14};
    localparam logic [3:0][7:0] C0P_PINS = {8'h24, 8'h20, 8'h14, 8'h10};
    localparam logic [3:0][7:0] C1N_PINS_32 = {8'h40, 8'h34, 8'h26, 8'h21};
    localparam logic [3:0][7:0] C1N_PINS = {8'h27, 8'h23, 8'h17, 8'h13};
    localparam logic [3:0][7:0] C1P_PINS_32 = {8'h37, 8'h33, 8'h25, 8'h20};
    localparam logic [3:0][7:0] C1P_PINS = {8'h26, 8'h22, 8'h16, 8'h12};

endpackage

// >>> hdl/dcc_channel.sv
`timescale 1ns/100ps
module dcc_channel (
    input wire logic clk,
    input wire logic reset,
    input wire logic result_in,
    input wire logic enable,
    input wire logic rise_ie,
    input wire logic fall_ie,
    input wire logic clr_rise,
    input wire logic clr_fall,
    output logic out_state,
    output logic routed,
    output logic rise_flag,
    output logic fall_flag,
    output logic rise_evt,
    output logic fall_evt,
    output logic irq_req
);
    import dcc_pkg::*;

    typedef struct packed {
        logic en_d;
        logic out_state;
        logic routed;
        logic rise_flag;
        logic fall_flag;
        logic rise_evt;
        logic fall_evt;
        logic irq_req;
    } dcc_chan_s;

    dcc_chan_s s_r;
    dcc_chan_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.en_d = enable;
        s_nxt.out_state = result_in;
        // Edges only while running two cycles, so power-up is not an edge
        s_nxt.rise_evt = enable && s_r.en_d && result_in && !s_r.out_state;
        s_nxt.fall_evt = enable && s_r.en_d && !result_in && s_r.out_state;
        if (clr_rise) begin
            s_nxt.rise_flag = 1'b0;
        end
        if (s_nxt.rise_evt) begin
            s_nxt.rise_flag = 1'b1;
        end
        if (clr_fall) begin
            s_nxt.fall_flag = 1'b0;
        end
        if (s_nxt.fall_evt) begin
            s_nxt.fall_flag = 1'b1;
        end
        s_nxt.routed = enable && result_in;
        s_nxt.irq_req = (s_nxt.rise_flag && rise_ie) ||
                        (s_nxt.fall_flag && fall_ie);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign out_state = s_r.out_state;
    assign routed = s_r.routed;
    assign rise_flag = s_r.rise_flag;
    assign fall_flag = s_r.fall_flag;
    assign rise_evt = s_r.rise_evt;
    assign fall_evt = s_r.fall_evt;
    assign irq_req = s_r.irq_req;

    property p_rise_sets;
        @(posedge clk) disable iff (reset)
        (enable && s_r.en_d && result_in && !s_r.out_state)
            |=> (rise_flag && rise_evt);
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise lost");

    property p_rise_holds;
        @(posedge clk) disable iff (reset)
        (rise_flag && !clr_rise) |=> rise_flag;
    endproperty
    a_rise_holds: assert property (p_rise_holds) else $error("rise off");

    property p_fall_sets;
        @(posedge clk) disable iff (reset)
        (enable && s_r.en_d && !result_in && s_r.out_state)
            |=> (fall_flag && fall_evt);
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("fall lost");

    property p_irq_req;
        @(posedge clk) disable iff (reset)
        1'b1 |=> irq_req == ((rise_flag && $past(rise_ie)) ||
                             (fall_flag && $past(fall_ie)));
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("irq wrong");

    property p_routed_low;
        @(posedge clk) disable iff (reset)
        !enable |=> !routed;
    endproperty
    a_routed_low: assert property (p_routed_low) else $error("routed");

    property p_out_state;
        @(posedge clk) disable iff (reset)
        1'b1 |=> out_state == $past(result_in);
    endproperty
    a_out_state: assert property (p_out_state) else $error("out");

endmodule

// >>> hdl/dcc_top.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module dcc_top (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [dcc_pkg::AXI_ADDR_W-1:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [dcc_pkg::AXI_DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [dcc_pkg::AXI_ADDR_W-1:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [dcc_pkg::AXI_DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    input wire logic VARIANT_32PIN,
    input wire logic CMP0_RESULT,
    input wire logic CMP1_RESULT,
    output logic CMP0_ENABLE,
    output logic CMP1_ENABLE,
    output logic [1:0] CMP0_RESPONSE_MODE,
    output logic [1:0] CMP1_RESPONSE_MODE,
    output logic [1:0] CMP0_POS_HYSTERESIS,
    output logic [1:0] CMP1_POS_HYSTERESIS,
    output logic [1:0] CMP0_NEG_HYSTERESIS,
    output logic [1:0] CMP1_NEG_HYSTERESIS,
    output logic [7:0] CMP0_POS_PIN,
    output logic [7:0] CMP0_NEG_PIN,
    output logic [7:0] CMP1_POS_PIN,
    output logic [7:0] CMP1_NEG_PIN,
    output logic CMP0_OUT_ROUTED,
    output logic CMP1_OUT_ROUTED,
    output logic CMP0_IRQ,
    output logic CMP1_IRQ,
    output logic IRQ
);
    import dcc_pkg::*;

    // ----------------------------------------------------------------
    // Types and helpers
    // ----------------------------------------------------------------
    typedef enum {
        REG_CTRL0, REG_INSEL0, REG_MODE0,
        REG_CTRL1, REG_INSEL1, REG_MODE1,
        REG_IRQ_ST, REG_IRQ_MASK, REG_NONE
    } dcc_reg_e;

    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [7:0] w_data;
        logic w_strb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0][7:0] ctrl;
        logic [1:0][7:0] insel;
        logic [1:0][7:0] mode;
        logic [3:0] irq_st;
        logic [3:0] irq_mask;
        logic irq;
        logic [1:0][7:0] neg_pin;
        logic [1:0][7:0] pos_pin;
    } dcc_top_s;

    function automatic dcc_reg_e decode(input logic [7:0] addr);
        if (addr == ADDR_CTRL0) begin
            return REG_CTRL0;
        end else if (addr == ADDR_INSEL0) begin
            return REG_INSEL0;
        end else if (addr == ADDR_MODE0) begin
            return REG_MODE0;
        end else if (addr == ADDR_CTRL1) begin
            return REG_CTRL1;
        end else if (addr == ADDR_INSEL1) begin
            return REG_INSEL1;
        end else if (addr == ADDR_MODE1) begin
            return REG_MODE1;
        end else if (addr == ADDR_IRQ_STATUS) begin
            return REG_IRQ_ST;
        end else if (addr == ADDR_IRQ_MASK) begin
            return REG_IRQ_MASK;
        end else begin
            return REG_NONE;
        end
    endfunction

    function automatic logic [7:0] pin_of(
        input logic [3:0][7:0] tbl32,
        input logic [3:0][7:0] tbl,
        input logic v32,
        input logic [1:0] code
    );
        return v32 ? tbl32[code] : tbl[code];
    endfunction

    dcc_top_s s_r;
    dcc_top_s s_nxt;
    logic [1:0] clr_rise;
    logic [1:0] clr_fall;
    logic [1:0] results;
    logic [1:0] ch_out;
    logic [1:0] ch_routed;
    logic [1:0] ch_rise;
    logic [1:0] ch_fall;
    logic [1:0] ch_rise_evt;
    logic [1:0] ch_fall_evt;
    logic [1:0] ch_irq;

    assign results = {CMP1_RESULT, CMP0_RESULT};

    // ----------------------------------------------------------------
    // Comparator channels
    // ----------------------------------------------------------------
    generate
        for (genvar c = 0; c < NUM_CMP; c++) begin : g_ch
            dcc_channel u_ch (
                .clk(CLK),
                .reset(RESET),
                .result_in(results[c]),
                .enable(s_r.ctrl[c][CTRL_EN_BIT]),
                .rise_ie(s_r.mode[c][MODE_RIE_BIT]),
                .fall_ie(s_r.mode[c][MODE_FIE_BIT]),
                .clr_rise(clr_rise[c]),
                .clr_fall(clr_fall[c]),
                .out_state(ch_out[c]),
                .routed(ch_routed[c]),
                .rise_flag(ch_rise[c]),
                .fall_flag(ch_fall[c]),
                .rise_evt(ch_rise_evt[c]),
                .fall_evt(ch_fall_evt[c]),
                .irq_req(ch_irq[c])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register file and bus slave
    // ----------------------------------------------------------------
    function automatic logic [7:0] ctrl_view(input int c);
        logic [7:0] v;
        v = s_r.ctrl[c] & CTRL_STORED;
        v[CTRL_OUT_BIT] = ch_out[c];
        v[CTRL_RISE_BIT] = ch_rise[c];
        v[CTRL_FALL_BIT] = ch_fall[c];
        return v;
    endfunction

    always_comb begin
        dcc_reg_e wsel;
        dcc_reg_e rsel;
        logic [7:0] rbyte;
        logic [3:0] w1c;
        logic wr;
        logic [1:0] cidx;
        s_nxt = s_r;
        clr_rise = 2'b00;
        clr_fall = 2'b00;
        w1c = 4'h0;
        rbyte = 8'h00;
        cidx = 2'b00;
        wsel = decode(s_r.aw_addr);
        rsel = decode(ARADDR);
        wr = s_r.aw_full && s_r.w_full && !s_r.bvalid;

        if (s_r.bvalid && BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        if (AWVALID && s_r.awready) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_addr = AWADDR;
        end
        if (WVALID && s_r.wready) begin
            s_nxt.w_full = 1'b1;
            s_nxt.w_data = WDATA[7:0];
            s_nxt.w_strb0 = WSTRB[0];
        end

        // Only byte lane 0 carries register bits; other lanes are ignored
        if (wr) begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            cidx = (wsel == REG_CTRL1 || wsel == REG_INSEL1 ||
                    wsel == REG_MODE1) ? 2'd1 : 2'd0;
            if (s_r.w_strb0) begin
                case (wsel)
                    REG_CTRL0, REG_CTRL1: begin
                        s_nxt.ctrl[cidx[0]] = s_r.w_data & CTRL_STORED;
                        // Writing one to a flag leaves it alone
                        clr_rise[cidx[0]] = !s_r.w_data[CTRL_RISE_BIT];
                        clr_fall[cidx[0]] = !s_r.w_data[CTRL_FALL_BIT];
                    end
                    REG_INSEL0, REG_INSEL1: begin
                        s_nxt.insel[cidx[0]] = INSEL_FORCED_ONES |
                            (s_r.w_data & INSEL_STORED);
                    end
                    REG_MODE0, REG_MODE1: begin
                        s_nxt.mode[cidx[0]] = s_r.w_data & MODE_STORED;
                    end
                    REG_IRQ_ST: begin
                        w1c = s_r.w_data[3:0];
                    end
                    REG_IRQ_MASK: begin
                        s_nxt.irq_mask = s_r.w_data[3:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Set wins over a write-one clear in the same cycle
        s_nxt.irq_st = (s_r.irq_st & ~w1c) |
            {ch_fall_evt[1], ch_rise_evt[1], ch_fall_evt[0], ch_rise_evt[0]};
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);

        if (s_r.rvalid && RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ARVALID && s_r.arready) begin
            case (rsel)
                REG_CTRL0: rbyte = ctrl_view(0);
                REG_CTRL1: rbyte = ctrl_view(1);
                REG_INSEL0: rbyte = s_r.insel[0] | INSEL_FORCED_ONES;
                REG_INSEL1: rbyte = s_r.insel[1] | INSEL_FORCED_ONES;
                REG_MODE0: rbyte = s_r.mode[0] & MODE_STORED;
                REG_MODE1: rbyte = s_r.mode[1] & MODE_STORED;
                REG_IRQ_ST: rbyte = {4'h0, s_r.irq_st};
                REG_IRQ_MASK: rbyte = {4'h0, s_r.irq_mask};
                default: rbyte = 8'h00;
            endcase
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = {24'h000000, rbyte};
            s_nxt.rresp = (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end

        s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_full && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;

        s_nxt.neg_pin[0] = pin_of(C0N_PINS_32, C0N_PINS, VARIANT_32PIN,
            s_nxt.insel[0][INSEL_NEG_LSB +: 2]);
        s_nxt.pos_pin[0] = pin_of(C0P_PINS_32, C0P_PINS, VARIANT_32PIN,
            s_nxt.insel[0][INSEL_POS_LSB +: 2]);
        s_nxt.neg_pin[1] = pin_of(C1N_PINS_32, C1N_PINS, VARIANT_32PIN,
            s_nxt.insel[1][INSEL_NEG_LSB +: 2]);
        s_nxt.pos_pin[1] = pin_of(C1P_PINS_32, C1P_PINS, VARIANT_32PIN,
            s_nxt.insel[1][INSEL_POS_LSB +: 2]);
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s_r <= '0;
            s_r.ctrl <= {CTRL_RESET, CTRL_RESET};
            s_r.insel <= {INSEL_RESET, INSEL_RESET};
            s_r.mode <= {MODE_RESET, MODE_RESET};
            s_r.irq_mask <= IRQ_MASK_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign AWREADY = s_r.awready;
    assign WREADY = s_r.wready;
    assign BVALID = s_r.bvalid;
    assign BRESP = s_r.bresp;
    assign ARREADY = s_r.arready;
    assign RVALID = s_r.rvalid;
    assign RDATA = s_r.rdata;
    assign RRESP = s_r.rresp;
    assign CMP0_ENABLE = s_r.ctrl[0][CTRL_EN_BIT];
    assign CMP1_ENABLE = s_r.ctrl[1][CTRL_EN_BIT];
    assign CMP0_RESPONSE_MODE = s_r.mode[0][MODE_RESP_LSB +: 2];
    assign CMP1_RESPONSE_MODE = s_r.mode[1][MODE_RESP_LSB +: 2];
    assign CMP0_POS_HYSTERESIS = s_r.ctrl[0][CTRL_HYP_LSB +: 2];
    assign CMP1_POS_HYSTERESIS = s_r.ctrl[1][CTRL_HYP_LSB +: 2];
    assign CMP0_NEG_HYSTERESIS = s_r.ctrl[0][CTRL_HYN_LSB +: 2];
    assign CMP1_NEG_HYSTERESIS = s_r.ctrl[1][CTRL_HYN_LSB +: 2];
    assign CMP0_POS_PIN = s_r.pos_pin[0];
    assign CMP0_NEG_PIN = s_r.neg_pin[0];
    assign CMP1_POS_PIN = s_r.pos_pin[1];
    assign CMP1_NEG_PIN = s_r.neg_pin[1];
    assign CMP0_OUT_ROUTED = ch_routed[0];
    assign CMP1_OUT_ROUTED = ch_routed[1];
    assign CMP0_IRQ = ch_irq[0];
    assign CMP1_IRQ = ch_irq[1];
    assign IRQ = s_r.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_insel_ones;
        @(posedge CLK) disable iff (RESET)
        (ARVALID && ARREADY && ARADDR == ADDR_INSEL0)
            |=> (RVALID && RDATA[7:6] == 2'b11 && RDATA[3:2] == 2'b11);
    endproperty
    a_insel_ones: assert property (p_insel_ones) else $error("insel");

    property p_neg0_pin;
        @(posedge CLK) disable iff (RESET)
        !RESET |=> CMP0_NEG_PIN == pin_of(C0N_PINS_32, C0N_PINS,
            $past(VARIANT_32PIN), s_r.insel[0][INSEL_NEG_LSB +: 2]);
    endproperty
    a_neg0_pin: assert property (p_neg0_pin) else $error("neg0 pin");

    property p_pos0_pin;
        @(posedge CLK) disable iff (RESET)
        !RESET |=> CMP0_POS_PIN == pin_of(C0P_PINS_32, C0P_PINS,
            $past(VARIANT_32PIN), s_r.insel[0][INSEL_POS_LSB +: 2]);
    endproperty
    a_pos0_pin: assert property (p_pos0_pin) else $error("pos0 pin");

    property p_mode_read;
        @(posedge CLK) disable iff (RESET)
        (ARVALID && ARREADY && ARADDR == ADDR_MODE0)
            |=> (RVALID && RDATA[7:6] == 2'b00 && RDATA[3:2] == 2'b00);
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode");

    property p_neg1_pin;
        @(posedge CLK) disable iff (RESET)
        !RESET |=> CMP1_NEG_PIN == pin_of(C1N_PINS_32, C1N_PINS,
            $past(VARIANT_32PIN), s_r.insel[1][INSEL_NEG_LSB +: 2]);
    endproperty
    a_neg1_pin: assert property (p_neg1_pin) else $error("neg1 pin");

endmodule

// >>> verification/dcc_cmp_model.sv
`timescale 1ns/100ps
module dcc_cmp_model (
    input wire logic clk,
    input wire logic [7:0] pos_pin,
    input wire logic [7:0] neg_pin,
    input wire logic [7:0] hi_pin,
    output logic result
);
    // ------------------------------------------------------------
    // Analog core
    // ------------------------------------------------------------
    // Only the pin named by hi_pin is above the others, so the
    // result also proves which pins the select codes routed
    always @(posedge clk) begin
        result <= (pos_pin == hi_pin) && (neg_pin != hi_pin);
    end
endmodule

// >>> verification/test_dual_comparator_control.sv
`timescale 1ns/100ps
module test_dual_comparator_control;
    import dcc_pkg::*;
    logic clk = 1'h0;
    logic reset, awvalid, wvalid, bready, arvalid, rready, var32;
    logic awready, wready, bvalid, arready, rvalid, r0, r1, rt0, irq0, irq;
    logic en0, en1, rt1, irq1;
    logic [7:0] awaddr, araddr, hi0, hi1, p0p, p0n, p1p, p1n;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, rs, bs, md0, md1, hp0, hp1, hn0, hn1;
    int error_cnt, compares;
    dcc_top i_dut (.CLK(clk), .RESET(reset), .AWVALID(awvalid),
        .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
        .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF), .BVALID(bvalid),
        .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
        .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid),
        .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .VARIANT_32PIN(var32), .CMP0_RESULT(r0), .CMP1_RESULT(r1),
        .CMP0_ENABLE(en0), .CMP1_ENABLE(en1), .CMP0_RESPONSE_MODE(md0),
        .CMP1_RESPONSE_MODE(md1), .CMP0_POS_HYSTERESIS(hp0),
        .CMP1_POS_HYSTERESIS(hp1), .CMP0_NEG_HYSTERESIS(hn0),
        .CMP1_NEG_HYSTERESIS(hn1), .CMP0_POS_PIN(p0p), .CMP0_NEG_PIN(p0n),
        .CMP1_POS_PIN(p1p), .CMP1_NEG_PIN(p1n), .CMP0_OUT_ROUTED(rt0),
        .CMP1_OUT_ROUTED(rt1), .CMP0_IRQ(irq0), .CMP1_IRQ(irq1), .IRQ(irq));
    dcc_cmp_model i_core0 (.clk(clk), .pos_pin(p0p), .neg_pin(p0n),
        .hi_pin(hi0), .result(r0));
    dcc_cmp_model i_core1 (.clk(clk), .pos_pin(p1p), .neg_pin(p1n),
        .hi_pin(hi1), .result(r1));
    always #5 clk = ~clk;
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (awready && awvalid) begin
                aw = 1'h1;
                awvalid <= 1'h0;
            end
            if (wready && wvalid) begin
                w = 1'h1;
                wvalid <= 1'h0;
            end
        end
        while (!bvalid) @(posedge clk);
        bs = bresp;
        bready <= 1'h0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        rs = rresp;
        rready <= 1'h0;
        chk({rs, d}, {er, e});
    endtask
    task automatic close_out;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rchk(ADDR_INSEL0, 32'hFF);
        rchk(ADDR_MODE0, 32'h02);
        rchk(ADDR_CTRL1, 32'h00);
        rchk(ADDR_INSEL1, 32'hFF);
        wr(ADDR_MODE0, 8'hFF);
        rchk(ADDR_MODE0, 32'h33);
        rchk(8'h40, 32'h0, RESP_SLVERR);
    endtask
    task automatic t_pins;
        logic [31:0] n0, q0, n1, q1;
        for (int v = 0; v < 2; v++) begin
            for (int c = 0; c < 4; c++) begin
                var32 <= v[0];
                n0 = v ? 32'h36322415 : 32'h25211511;
                q0 = v ? 32'h35312314 : 32'h24201410;
                n1 = v ? 32'h40342621 : 32'h27231713;
                q1 = v ? 32'h37332520 : 32'h26221612;
                wr(ADDR_INSEL0, {2'h0, c[1:0], 2'h0, c[1:0]});
                wr(ADDR_INSEL1, {2'h0, c[1:0], 2'h0, c[1:0]});
                repeat (2) @(posedge clk);
                chk({26'h0, p0n}, {26'h0, n0[c*8+:8]});
                chk({26'h0, p0p}, {26'h0, q0[c*8+:8]});
                chk({26'h0, p1n}, {26'h0, n1[c*8+:8]});
                chk({26'h0, p1p}, {26'h0, q1[c*8+:8]});
                rchk(ADDR_INSEL0, {24'h0, 2'h3, c[1:0], 2'h3, c[1:0]});
            end
        end
    endtask
    task automatic t_edges;
        var32 <= 1'h0;
        wr(ADDR_INSEL0, 8'h00);
        wr(ADDR_MODE0, 8'h30);
        wr(ADDR_IRQ_MASK, 8'h03);
        wr(ADDR_CTRL0, 8'h80);
        repeat (3) @(posedge clk);
        hi0 <= 8'h10;
        repeat (5) @(posedge clk);
        chk({33'h0, rt0}, 34'h1);
        chk({33'h0, irq0}, 34'h1);
        chk({33'h0, irq}, 34'h1);
        rchk(ADDR_CTRL0, 32'hE0);
        wr(ADDR_CTRL0, 8'hA0);
        rchk(ADDR_CTRL0, 32'hE0);
        hi0 <= 8'h00;
        repeat (5) @(posedge clk);
        rchk(ADDR_CTRL0, 32'hB0);
        wr(ADDR_CTRL0, 8'h80);
        rchk(ADDR_CTRL0, 32'h80);
        chk({33'h0, irq0}, 34'h0);
        rchk(ADDR_IRQ_STATUS, 32'h3);
        wr(ADDR_IRQ_STATUS, 8'h03);
        @(posedge clk);
        chk({33'h0, irq}, 34'h0);
        wr(ADDR_CTRL0, 8'h00);
        hi0 <= 8'h10;
        repeat (5) @(posedge clk);
        chk({33'h0, rt0}, 34'h0);
        rchk(ADDR_CTRL0, 32'h40);
    endtask
    // Comparator 1 path, field outputs and write responses
    task automatic t_cmp1;
        wr(ADDR_CTRL0, 8'h06);
        wr(ADDR_INSEL1, 8'h00);
        wr(ADDR_MODE1, 8'h13);
        wr(ADDR_CTRL1, 8'h8B);
        chk({20'h0, en0, en1, md0, md1, hp0, hn0, hp1, hn1}, 34'h136B);
        rchk(ADDR_MODE1, 32'h13);
        rchk(ADDR_CTRL0, 32'h46);
        repeat (3) @(posedge clk);
        hi1 <= 8'h12;
        repeat (5) @(posedge clk);
        chk({32'h0, rt1, irq1}, 34'h2);
        hi1 <= 8'h00;
        repeat (5) @(posedge clk);
        chk({32'h0, rt1, irq1}, 34'h1);
        rchk(ADDR_CTRL1, 32'hBB);
        rchk(ADDR_IRQ_STATUS, 32'hC);
        chk({33'h0, irq}, 34'h0);
        wr(8'h40, 8'h00);
        chk({32'h0, bs}, {32'h0, RESP_SLVERR});
        wr(ADDR_IRQ_MASK, 8'h0C);
        chk({32'h0, bs}, {32'h0, RESP_OKAY});
        chk({33'h0, irq}, 34'h1);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, var32} = '0;
        {awaddr, araddr, hi0, hi1, wdata, error_cnt, compares} = '0;
        reset = 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        repeat (2) @(posedge clk);
        t_reset();
        t_pins();
        t_edges();
        t_cmp1();
        close_out();
    end
    // Whole run needs a few hundred cycles; this only cuts a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
endmodule
